// *** verilog/dbs_pkg.sv ***
package dbs_pkg;

    // Terminal counts and mapping digit layout.
    localparam int          DBS_N_OUT_TERM   = 6;
    localparam int          DBS_N_IN_TERM    = 8;
    localparam int          DBS_N_OUT_DIGIT  = 4;
    localparam int          DBS_DIGIT_W      = 4;
    localparam int          DBS_DIG_BRAKE    = 1;
    localparam int          DBS_DIG_ANSWER   = 2;
    localparam logic [3:0]  DBS_TERM_NONE    = 4'h0;

    // Register byte offsets.
    localparam logic [7:0]  DBS_OFS_OUTMAP   = 8'h00;
    localparam logic [7:0]  DBS_OFS_INMAP    = 8'h04;
    localparam logic [7:0]  DBS_OFS_FUNC     = 8'h08;
    localparam logic [7:0]  DBS_OFS_STATUS   = 8'h0C;
    localparam logic [7:0]  DBS_OFS_MASK     = 8'h10;
    localparam logic [7:0]  DBS_OFS_STATE    = 8'h14;

    // Values after reset.
    localparam logic [15:0] DBS_RST_OUTMAP   = 16'h0000;
    localparam logic [15:0] DBS_RST_INMAP    = 16'h0000;
    localparam logic [3:0]  DBS_RST_FUNC     = 4'h0;
    localparam logic [2:0]  DBS_RST_STATUS   = 3'h0;
    localparam logic [2:0]  DBS_RST_MASK     = 3'h0;

    // Status and mask bit positions.
    localparam int          DBS_ST_W         = 3;
    localparam int          DBS_ST_MAPERR    = 0;
    localparam int          DBS_ST_CIRCERR   = 1;
    localparam int          DBS_ST_REFUSED   = 2;

    // AXI response codes.
    localparam logic [1:0]  DBS_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  DBS_RESP_SLVERR  = 2'h2;

    // Disagreement window.
    localparam int          DBS_CLK_KHZ      = 250000;
    localparam int          DBS_DISAGREE_MS  = 140;
    localparam int          DBS_DISAGREE_CYC = DBS_DISAGREE_MS * DBS_CLK_KHZ;
    localparam int          DBS_TMR_W        = 27;

endpackage

// *** verilog/dbs_disagree_timer.sv ***
`timescale 1ns/1ps

module dbs_disagree_timer
    import dbs_pkg::*;
#(
    parameter int LIMIT = DBS_DISAGREE_CYC
)(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic disagree,
    output logic      fire
);

    localparam logic [DBS_TMR_W-1:0] LAST = DBS_TMR_W'(LIMIT - 1);

    logic [DBS_TMR_W-1:0] count;
    wire                  at_last = (count == LAST);

    // The count clears on agreement and saturates so the alarm fires once per episode.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= '0;
            fire  <= 1'b0;
        end
        else
        begin
            count <= !disagree ? '0 : (at_last ? count : count + 1'b1);
            fire  <= disagree && (count == LAST - 1'b1);
        end
    end

endmodule

// *** verilog/dbs_top.sv ***
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module dbs_top
    import dbs_pkg::*;
#(
    parameter int DISAGREE_CYCLES = DBS_DISAGREE_CYC
)(
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      high_power_strap,
    input  wire logic                      brake_cmd,
    input  wire logic [DBS_N_IN_TERM-1:0]  term_in,
    output logic      [DBS_N_OUT_TERM-1:0] term_out,
    output logic                           brake_request_out,
    output logic                           brake_answer_in,
    output logic                           request_mapping_error_alarm,
    output logic                           brake_circuit_error_alarm,
    output logic                           irq,
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);

    // ==========================================================
    // Register state
    // ==========================================================
    logic [15:0]                output_map_param;
    logic [15:0]                input_map_param;
    logic [3:0]                 func_state;
    logic [DBS_ST_W-1:0]        status;
    logic [DBS_ST_W-1:0]        mask;
    logic                       variant_hp;
    logic                       strap_taken;
    logic                       map_err_q;

    // ==========================================================
    // Write channel
    // ==========================================================
    logic                       aw_full;
    logic                       w_full;
    logic [7:0]                 aw_addr;
    logic [31:0]                w_data;
    logic [3:0]                 w_strb;

    wire         aw_take      = s_axi_awvalid && s_axi_awready;
    wire         w_take       = s_axi_wvalid && s_axi_wready;
    wire         do_write     = aw_full && w_full && !s_axi_bvalid;
    wire         next_aw_full = (aw_full || aw_take) && !do_write;
    wire         next_w_full  = (w_full || w_take) && !do_write;
    wire         next_bvalid  = do_write || (s_axi_bvalid && !s_axi_bready);
    wire [31:0]  byte_mask    = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

    wire         wr_outmap    = do_write && (aw_addr == DBS_OFS_OUTMAP);
    wire         wr_inmap     = do_write && (aw_addr == DBS_OFS_INMAP);
    wire         wr_func      = do_write && (aw_addr == DBS_OFS_FUNC);
    wire         wr_status    = do_write && (aw_addr == DBS_OFS_STATUS);
    wire         wr_mask      = do_write && (aw_addr == DBS_OFS_MASK);
    wire         wr_state     = do_write && (aw_addr == DBS_OFS_STATE);
    wire         wr_hit       = wr_outmap || wr_inmap || wr_func || wr_status
                                || wr_mask || wr_state;

    wire [31:0]  merged_out   = ({16'h0000, output_map_param} & ~byte_mask) | (w_data & byte_mask);
    wire [31:0]  merged_in    = ({16'h0000, input_map_param} & ~byte_mask) | (w_data & byte_mask);
    wire [31:0]  merged_func  = ({28'h0000000, func_state} & ~byte_mask) | (w_data & byte_mask);
    wire [31:0]  merged_mask  = ({29'h00000000, mask} & ~byte_mask) | (w_data & byte_mask);
    wire [DBS_ST_W-1:0] st_clr = wr_status ? (w_data[DBS_ST_W-1:0] & byte_mask[DBS_ST_W-1:0])
                                           : '0;

    // Low-power variants keep the request digit unallocated.
    localparam int BRK_LO = DBS_DIG_BRAKE * DBS_DIGIT_W;
    wire [3:0]   wr_brake_dig = merged_out[BRK_LO +: DBS_DIGIT_W];
    wire         map_refused  = wr_outmap && !variant_hp && (wr_brake_dig != DBS_TERM_NONE);
    wire [15:0]  next_outmap  = variant_hp ? merged_out[15:0]
                                           : (merged_out[15:0] & ~(16'h000F << BRK_LO));

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= DBS_RESP_OKAY;
        end
        else
        begin
            aw_full       <= next_aw_full;
            w_full        <= next_w_full;
            s_axi_awready <= !next_aw_full && !next_bvalid;
            s_axi_wready  <= !next_w_full && !next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            if (aw_take)
            begin
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_take)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                s_axi_bresp <= wr_hit ? DBS_RESP_OKAY : DBS_RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // Configuration registers and variant capture
    // ==========================================================
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            output_map_param <= DBS_RST_OUTMAP;
            input_map_param  <= DBS_RST_INMAP;
            func_state       <= DBS_RST_FUNC;
            mask             <= DBS_RST_MASK;
            variant_hp       <= 1'b0;
            strap_taken      <= 1'b0;
        end
        else
        begin
            strap_taken <= 1'b1;
            if (!strap_taken)
            begin
                variant_hp <= high_power_strap;
            end
            if (wr_outmap)
            begin
                output_map_param <= next_outmap;
            end
            if (wr_inmap)
            begin
                input_map_param <= merged_in[15:0];
            end
            if (wr_func)
            begin
                func_state <= merged_func[3:0];
            end
            if (wr_mask)
            begin
                mask <= merged_mask[DBS_ST_W-1:0];
            end
        end
    end

    // ==========================================================
    // Terminal input synchroniser
    // ==========================================================
    logic [DBS_N_IN_TERM-1:0] in_s1;
    logic [DBS_N_IN_TERM-1:0] in_s2;
    logic [DBS_N_IN_TERM-1:0] in_s3;
    logic [DBS_N_IN_TERM-1:0] in_filt;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            in_s1   <= '0;
            in_s2   <= '0;
            in_s3   <= '0;
            in_filt <= '0;
        end
        else
        begin
            in_s1   <= term_in;
            in_s2   <= in_s1;
            in_s3   <= in_s2;
            in_filt <= (in_s2 & in_s3) | (in_filt & (in_s2 ^ in_s3));
        end
    end

    // ==========================================================
    // Mapping decode
    // ==========================================================
    wire [3:0] brake_dig  = output_map_param[BRK_LO +: DBS_DIGIT_W];
    wire [3:0] answer_dig = input_map_param[DBS_DIG_ANSWER*DBS_DIGIT_W +: DBS_DIGIT_W];
    wire [3:0] answer_idx = answer_dig - 4'h1;
    wire       out_mapped = (brake_dig != DBS_TERM_NONE) && (brake_dig <= 4'(DBS_N_OUT_TERM));
    wire       in_mapped  = (answer_dig != DBS_TERM_NONE) && (answer_dig <= 4'(DBS_N_IN_TERM));
    wire       answer_closed = in_mapped && in_filt[answer_idx[2:0]];

    logic [DBS_N_OUT_DIGIT-1:0] shares_brake;

    genvar d;
    generate
        for (d = 0; d < DBS_N_OUT_DIGIT; d++)
        begin : g_digit
            wire [3:0] dig = output_map_param[d*DBS_DIGIT_W +: DBS_DIGIT_W];
            assign shares_brake[d] = (d != DBS_DIG_BRAKE) && out_mapped && (dig == brake_dig);
        end
    endgenerate

    wire map_err   = |shares_brake;
    wire both_map  = out_mapped && in_mapped;
    wire brake_fn  = brake_cmd && both_map && !map_err;
    wire disagree  = both_map && (brake_request_out == answer_closed);

    wire [DBS_N_OUT_DIGIT-1:0] func_level = {func_state[3:2], brake_request_out, func_state[0]};

    // Each terminal carries the OR of every function allocated to it.
    logic [DBS_N_OUT_TERM-1:0] next_term;
    genvar t;
    generate
        for (t = 0; t < DBS_N_OUT_TERM; t++)
        begin : g_term
            logic [DBS_N_OUT_DIGIT-1:0] hit;
            always_comb
            begin
                for (int k = 0; k < DBS_N_OUT_DIGIT; k++)
                begin
                    hit[k] = func_level[k]
                             && (output_map_param[k*DBS_DIGIT_W +: DBS_DIGIT_W] == 4'(t + 1));
                end
            end
            assign next_term[t] = |hit;
        end
    endgenerate

    // ==========================================================
    // Disagreement supervision
    // ==========================================================
    logic circ_fire;

    dbs_disagree_timer #(
        .LIMIT    (DISAGREE_CYCLES)
    ) u_timer (
        .clk      (clk),
        .nrst     (nrst),
        .disagree (disagree),
        .fire     (circ_fire)
    );

    // ==========================================================
    // Status, interrupt and pin outputs
    // ==========================================================
    wire [DBS_ST_W-1:0] st_set      = {map_refused, circ_fire, map_err && !map_err_q};
    wire [DBS_ST_W-1:0] next_status = (status & ~st_clr) | st_set;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            status                      <= DBS_RST_STATUS;
            map_err_q                   <= 1'b0;
            irq                         <= 1'b0;
            term_out                    <= '0;
            brake_request_out           <= 1'b0;
            brake_answer_in             <= 1'b0;
            request_mapping_error_alarm <= 1'b0;
            brake_circuit_error_alarm   <= 1'b0;
        end
        else
        begin
            status                      <= next_status;
            map_err_q                   <= map_err;
            irq                         <= |(next_status & mask);
            term_out                    <= next_term;
            brake_request_out           <= brake_fn;
            brake_answer_in             <= answer_closed;
            request_mapping_error_alarm <= map_err;
            brake_circuit_error_alarm   <= next_status[DBS_ST_CIRCERR];
        end
    end

    // ==========================================================
    // Read channel
    // ==========================================================
    wire [31:0] state_word = {14'h0000, in_filt, term_out, map_err, variant_hp,
                              brake_answer_in, brake_request_out};
    wire        ar_take     = s_axi_arvalid && s_axi_arready;
    wire        next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);
    wire [7:0]  ra          = {s_axi_araddr[7:2], 2'b00};
    wire        rd_hit      = (ra <= DBS_OFS_STATE);
    wire [31:0] rd_word     = (ra == DBS_OFS_OUTMAP) ? {16'h0000, output_map_param} :
                              (ra == DBS_OFS_INMAP)  ? {16'h0000, input_map_param}  :
                              (ra == DBS_OFS_FUNC)   ? {28'h0000000, func_state}    :
                              (ra == DBS_OFS_STATUS) ? {29'h00000000, status}       :
                              (ra == DBS_OFS_MASK)   ? {29'h00000000, mask}         :
                              (ra == DBS_OFS_STATE)  ? state_word                   :
                                                       32'h00000000;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= DBS_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_take)
            begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? DBS_RESP_OKAY : DBS_RESP_SLVERR;
            end
        end
    end

endmodule

// *** testbench/dbs_top_checker.sv ***
`timescale 1ns/1ps

module dbs_top_checker
#(
    parameter int DISAGREE_CYCLES = dbs_pkg::DBS_DISAGREE_CYC
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic brake_cmd,
    input wire logic brake_request_out,
    input wire logic brake_answer_in,
    input wire logic request_mapping_error_alarm,
    input wire logic brake_circuit_error_alarm,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // =========================================================
    // Run of cycles in which request and answer levels are equal
    // =========================================================
    int eq_run;

    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            eq_run <= 0;
        else
            eq_run <= (brake_request_out == brake_answer_in) ? eq_run + 1 : 0;

    // =========================================================
    // Properties
    // =========================================================
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_req_cmd: assert property (brake_request_out |-> $past(brake_cmd))
        else $error("brake request without command");
    a_map_block: assert property (request_mapping_error_alarm &&
        $past(request_mapping_error_alarm) |-> !brake_request_out)
        else $error("brake request during mapping error");
    a_alarm_cause: assert property ($rose(brake_circuit_error_alarm)
        |-> eq_run >= DISAGREE_CYCLES - 3)
        else $error("circuit alarm without long disagreement");
    a_alarm_sticky: assert property ($fell(brake_circuit_error_alarm)
        |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("circuit alarm cleared without a write");
    a_wr_resp: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_rd_resp: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
endmodule

bind dbs_top dbs_top_checker #(.DISAGREE_CYCLES(DISAGREE_CYCLES)) u_chk (
    .clk, .nrst, .brake_cmd, .brake_request_out, .brake_answer_in,
    .request_mapping_error_alarm, .brake_circuit_error_alarm,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready
);

// *** testbench/dbs_brake_circuit_model.sv ***
`timescale 1ns/1ps

module dbs_brake_circuit_model (
    input  wire logic       clk,
    input  wire logic       req_pin,
    input  wire logic [3:0] delay,
    input  wire logic       stuck,
    output logic            answer_pin
);
    // =========================================================
    // Relay and contactor chain
    // =========================================================
    logic [15:0] coil = 16'h0;

    initial answer_pin = 1'b1;

    // A stuck chain keeps the answer contact closed whatever the request.
    always @(posedge clk)
    begin
        coil <= {coil[14:0], req_pin};
        answer_pin <= stuck | ~coil[delay];
    end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps

module tb_top
    import dbs_pkg::*;
;
    localparam int NCYC = 20;
    logic        clk = 0, nrst = 0, high_power_strap = 1, brake_cmd = 0;
    logic [7:0]  term_in, other = 8'h0, s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [5:0]  term_out;
    logic        brake_request_out, brake_answer_in, irq, ans, stuck = 0;
    logic        request_mapping_error_alarm, brake_circuit_error_alarm;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0, dly = 4'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          err_total = 0, cmp_count = 0, seed = 32'hcdcf, t = 1, x = 2, a = 1, om;

    always #2 clk = ~clk;

    always_comb
    begin
        term_in = other;
        term_in[a-1] = ans;
    end

    dbs_top #(.DISAGREE_CYCLES(NCYC)) dut (
        .clk, .nrst, .high_power_strap, .brake_cmd, .term_in, .term_out,
        .brake_request_out, .brake_answer_in, .request_mapping_error_alarm,
        .brake_circuit_error_alarm, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    dbs_brake_circuit_model u_dbc (.clk, .req_pin(term_out[t-1]), .delay(dly), .stuck,
        .answer_pin(ans));

    // =========================================================
    // Checking and bus tasks
    // =========================================================
    task automatic report_and_stop();
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic wait_edge(inout int n);
        @(posedge clk);
        n++;
        if (n > 50)
        begin
            err_total++;
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er,
                      input logic [3:0] st = 4'hF);
        int n;
        n = 0;
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            wait_edge(n);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            wait_edge(n);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask

    // Expected terminal levels: each mapped function ORed onto its terminal.
    function automatic logic [5:0] exp_out(int m, int fn, bit rq);
        logic [5:0] r;
        r = 6'h0;
        for (int k = 0; k < 4; k++)
            if (((m >> 4*k) & 15) inside {[1:6]} && (k == 1 ? rq : fn[k]))
                r[((m >> 4*k) & 15) - 1] = 1'b1;
        return r;
    endfunction

    // =========================================================
    // Main sequence
    // =========================================================
    initial
    begin
        t = 1 + $unsigned($random(seed)) % 6;
        x = t % 6 + 1;
        a = 1 + $unsigned($random(seed)) % 8;
        other = $random(seed);
        om = (x << 8) | (t << 4) | x;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++)
            rd(8'(4*i), 32'h0, DBS_RESP_OKAY);
        rd(8'h18, 32'h0, DBS_RESP_SLVERR);
        wr(8'h1C, 32'h1, DBS_RESP_SLVERR);
        wr(DBS_OFS_OUTMAP, 32'hFFFF, DBS_RESP_OKAY, 4'h2);
        rd(DBS_OFS_OUTMAP, 32'hFF00, DBS_RESP_OKAY);
        wr(DBS_OFS_OUTMAP, om, DBS_RESP_OKAY);
        wr(DBS_OFS_INMAP, a << 8, DBS_RESP_OKAY);
        for (int i = 0; i < 16; i++)
        begin
            wr(DBS_OFS_FUNC, i, DBS_RESP_OKAY);
            chk(term_out, exp_out(om, i, 0));
        end
        wr(DBS_OFS_FUNC, 32'h0, DBS_RESP_OKAY);
        for (int i = 0; i < 2; i++)
        begin
            dly <= i ? 4'h8 : 4'h0;
            brake_cmd <= 1'b1;
            repeat (3) @(posedge clk);
            chk(brake_request_out, 32'h1);
            chk(term_out, exp_out(om, 0, 1));
            repeat (30) @(posedge clk);
            chk(brake_answer_in, 32'h0);
            rd(DBS_OFS_STATE, {term_in, exp_out(om, 0, 1), 4'h5}, DBS_RESP_OKAY);
            brake_cmd <= 1'b0;
            repeat (30) @(posedge clk);
            chk(brake_answer_in, 32'h1);
            chk(brake_circuit_error_alarm, 32'h0);
        end
        stuck <= 1'b1;
        brake_cmd <= 1'b1;
        repeat (NCYC - 1) @(posedge clk);
        chk(brake_circuit_error_alarm, 32'h0);
        repeat (4) @(posedge clk);
        chk(brake_circuit_error_alarm, 32'h1);
        chk(irq, 32'h0);
        wr(DBS_OFS_MASK, 32'h2, DBS_RESP_OKAY);
        chk(irq, 32'h1);
        brake_cmd <= 1'b0;
        rd(DBS_OFS_STATUS, 32'h2, DBS_RESP_OKAY);
        wr(DBS_OFS_STATUS, 32'h2, DBS_RESP_OKAY);
        chk(brake_circuit_error_alarm, 32'h0);
        chk(irq, 32'h0);
        stuck <= 1'b0;
        wr(DBS_OFS_OUTMAP, (om & 32'hFFF0) | t, DBS_RESP_OKAY);
        brake_cmd <= 1'b1;
        repeat (3) @(posedge clk);
        chk(request_mapping_error_alarm, 32'h1);
        chk(brake_request_out, 32'h0);
        rd(DBS_OFS_STATUS, 32'h1, DBS_RESP_OKAY);
        brake_cmd <= 1'b0;
        wr(DBS_OFS_OUTMAP, om, DBS_RESP_OKAY);
        wr(DBS_OFS_STATUS, 32'h1, DBS_RESP_OKAY);
        rd(DBS_OFS_STATUS, 32'h0, DBS_RESP_OKAY);
        high_power_strap <= 1'b0;
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        wr(DBS_OFS_OUTMAP, om, DBS_RESP_OKAY);
        rd(DBS_OFS_OUTMAP, om & 32'hFF0F, DBS_RESP_OKAY);
        rd(DBS_OFS_STATUS, 32'h4, DBS_RESP_OKAY);
        report_and_stop();
    end
endmodule
